// ==== tdc_cfg_bank.sv ====
// Configuration register bank behind the serial interface
// What this block does
// - Seven 32-bit configuration words, selected by register number.
// - Upper 24 bits are settings; never returned by a tag read (the check read returns word 1 bits 31:24).
// - Low byte of each word is a readable user tag, reset to zero.
// - Writes and reads move most significant bit first.
// - Result read of address 5 returns top byte of word 1.
// - Word 0 bits 8,9,10 invert start, stop a, stop b edges; default 1.
// - Word 0 bit 11 selects measurement range two; default 1.
// - Word 0 bit 12 disables auto calibration (0); bit 13 enables calc (1).
// - Word 0 bit 14 selects temperature cycle clock source; default 1.
// - Word 0 bit 15 selects temperature dummy cycle count; default 0.
// - Word 0 bits 20-21 high-speed clock predivider; default 0.
// - Word 0 bits 24-27 fire clock predivider; default 2.
// - Word 1 hit select a in 24-27, b in 28-31; default 5.
// - Word 1 bit 23 enables fast initialisation; default 0.
// - Words 2,3,4 carry 16-bit delay values in bits 8-23; default 0.
// - Word 2 bits 27,28 enable both-edge stops a and b; default 0.
// - Word 3 bits 27-28 range-two timeout (3); bit 29 error value (0).
// - Word 5 bits 8-23 phase pattern, 24-26 repeat count; default 0.
// - Word 6 bit 12 double, bit 13 quadruple resolution; default 0.
// - Word 6 bit 31 enables the analog input section; default 0.
`timescale 1ns/10ps
`default_nettype none
module tdc_cfg_bank
   import tdc_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic spi_sclk,
   input wire logic spi_ssn_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   output cfg_fields_t cfg
);
   logic [31:0] regs_r [NUM_REGS];
   spi_pins_t pins_s;
   spi_frame_t frame;
   logic [7:0] tx_byte;
   logic [NUM_REGS*WORD_BITS-1:0] regs_flat;

   // ==========================================================
   // Reset values per word
   function automatic logic [31:0] default_word(input logic [2:0] idx);
      logic [31:0] v;
      v = CFG_ZERO_RESET;
      unique case (idx)
         REG_CFG0: v = CFG0_RESET;
         REG_CFG1: v = CFG1_RESET;
         REG_CFG3: v = CFG3_RESET;
         default: v = CFG_ZERO_RESET;
      endcase
      return v;
   endfunction

   // ==========================================================
   // Pin crossing and frame engine
   pin_sync #(
      .WIDTH(3),
      .INIT(PINS_IDLE)
   ) u_sync (
      .mclk(mclk),
      .srst(srst),
      .d({spi_sclk, spi_ssn_n, spi_mosi}),
      .q(pins_s)
   );

   spi_frame_rx u_rx (
      .mclk(mclk),
      .srst(srst),
      .pins(pins_s),
      .tx_byte(tx_byte),
      .frame(frame),
      .miso(spi_miso),
      .miso_oe(spi_miso_oe)
   );

   // ==========================================================
   // Command decode
   wire [2:0] op_addr = frame.opcode[2:0];
   wire addr_ok = (op_addr <= LAST_REG);
   wire is_write = (frame.opcode[7:3] == OP_WRITE_PFX);
   wire is_result = (frame.opcode[7:3] == OP_RESULT_PFX);
   wire is_id = (frame.opcode[7:3] == OP_ID_PFX);
   wire wr_commit = frame.word_valid && is_write && addr_ok;
   wire pwr_cmd = frame.opcode_valid && (frame.opcode == OP_POWER_RESET);
   wire check_rd = is_result && (op_addr == CHECK_ADDR);
   wire id_rd = is_id && addr_ok;

   // Read byte: only tag bytes and the check byte ever leave
   assign tx_byte = check_rd ? regs_r[REG_CFG1][CHECK_LSB +: TAG_BITS] :
                    id_rd ? regs_r[op_addr][TAG_BITS-1:0] :
                    8'h00;

   // ==========================================================
   // Storage; whole word lands in one edge, reset wins over write
   always_ff @(posedge mclk) begin
      if (srst || pwr_cmd) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_r[i] <= default_word(3'(i));
         end
      end else if (wr_commit) begin
         regs_r[op_addr] <= frame.word;
      end
   end

   for (genvar g = 0; g < NUM_REGS; g++) begin : g_flat
      assign regs_flat[g*WORD_BITS +: WORD_BITS] = regs_r[g];
   end

   // ==========================================================
   // Word 0 fields
   assign cfg.start_edge_invert = regs_r[REG_CFG0][START_INV_BIT];
   assign cfg.stop_a_edge_invert = regs_r[REG_CFG0][STOPA_INV_BIT];
   assign cfg.stop_b_edge_invert = regs_r[REG_CFG0][STOPB_INV_BIT];
   assign cfg.range_two_select = regs_r[REG_CFG0][RANGE2_BIT];
   assign cfg.auto_cal_disable = regs_r[REG_CFG0][NOCAL_BIT];
   assign cfg.cal_calc_enable = regs_r[REG_CFG0][CALC_BIT];
   assign cfg.temp_cycle_clock_select = regs_r[REG_CFG0][TCLK_BIT];
   assign cfg.temp_dummy_cycles = regs_r[REG_CFG0][DUMMY_BIT];
   assign cfg.temp_cycle_time = regs_r[REG_CFG0][TCYC_BIT];
   assign cfg.temp_port_count = regs_r[REG_CFG0][TPORT_BIT];
   assign cfg.hs_clock_prediv = regs_r[REG_CFG0][HSDIV_LSB +: 2];
   assign cfg.fire_clock_prediv = regs_r[REG_CFG0][FIREDIV_LSB +: 4];

   // Word 1 fields
   assign cfg.hit_select_a = regs_r[REG_CFG1][HITA_LSB +: 4];
   assign cfg.hit_select_b = regs_r[REG_CFG1][HITB_LSB +: 4];
   assign cfg.fast_init_enable = regs_r[REG_CFG1][FASTINIT_BIT];

   // Words 2 to 4 fields
   assign cfg.delay_value_a = regs_r[REG_CFG2][DELAY_LSB +: 16];
   assign cfg.delay_value_b = regs_r[REG_CFG3][DELAY_LSB +: 16];
   assign cfg.delay_value_c = regs_r[REG_CFG4][DELAY_LSB +: 16];
   assign cfg.stop_a_both_edges = regs_r[REG_CFG2][BOTHA_BIT];
   assign cfg.stop_b_both_edges = regs_r[REG_CFG2][BOTHB_BIT];
   assign cfg.range_two_timeout_select = regs_r[REG_CFG3][TIMO_LSB +: 2];
   assign cfg.timeout_error_enable = regs_r[REG_CFG3][ERRVAL_BIT];

   // Words 5 and 6 fields
   assign cfg.pulse_phase_pattern = regs_r[REG_CFG5][PHASE_LSB +: 16];
   assign cfg.fire_repeat_count = regs_r[REG_CFG5][REPEAT_LSB +: 3];
   assign cfg.resolution_x2_enable = regs_r[REG_CFG6][RESX2_BIT];
   assign cfg.resolution_x4_enable = regs_r[REG_CFG6][RESX4_BIT];
   assign cfg.analog_enable = regs_r[REG_CFG6][ANALOG_BIT];

   // ==========================================================
   // Checks
   a_write_commit: assert property (@(posedge mclk) disable iff (srst)
      wr_commit && !pwr_cmd |=> regs_r[$past(op_addr)] == $past(frame.word))
      else $error("write did not land in addressed word");
   a_hold_between: assert property (@(posedge mclk) disable iff (srst)
      !wr_commit && !pwr_cmd |=> $stable(regs_flat))
      else $error("register changed without a complete write");
   a_reset_defaults: assert property (@(posedge mclk) disable iff (srst)
      $fell(srst) |-> regs_r[0] == CFG0_RESET && regs_r[1] == CFG1_RESET &&
         regs_r[2] == 32'h00000000 && regs_r[3] == CFG3_RESET &&
         regs_r[4] == 32'h00000000 && regs_r[5] == 32'h00000000 &&
         regs_r[6] == 32'h00000000)
      else $error("defaults wrong after reset release");
   a_cmd_reset: assert property (@(posedge mclk) disable iff (srst)
      pwr_cmd |=> cfg.hit_select_a == 4'h5 && cfg.fire_clock_prediv == 4'h2 &&
         cfg.range_two_timeout_select == 2'h3 && regs_r[6] == 32'h00000000)
      else $error("reset command did not restore defaults");
   a_check_read: assert property (@(posedge mclk) disable iff (srst)
      frame.opcode_valid && check_rd |-> tx_byte == regs_r[1][31:24])
      else $error("check read byte differs from word 1 top byte");
   a_id_only: assert property (@(posedge mclk) disable iff (srst)
      frame.opcode_valid && id_rd |-> tx_byte == regs_r[op_addr][7:0])
      else $error("tag read returned non-tag bits");
   c_write: cover property (@(posedge mclk) disable iff (srst) wr_commit);
   c_check_read: cover property (@(posedge mclk) disable iff (srst)
      frame.opcode_valid && check_rd);
   c_id_read: cover property (@(posedge mclk) disable iff (srst) frame.opcode_valid && id_rd);
   c_cmd_reset: cover property (@(posedge mclk) disable iff (srst) pwr_cmd);
endmodule
`default_nettype wire

// ==== tdc_cfg_pkg.sv ====
// Constants, field positions and carrier types of the configuration bank
package tdc_cfg_pkg;

   // ==========================================================
   // Register file shape
   localparam int NUM_REGS = 7;
   localparam int WORD_BITS = 32;
   localparam int TAG_BITS = 8;
   localparam logic [2:0] REG_CFG0 = 3'h0;
   localparam logic [2:0] REG_CFG1 = 3'h1;
   localparam logic [2:0] REG_CFG2 = 3'h2;
   localparam logic [2:0] REG_CFG3 = 3'h3;
   localparam logic [2:0] REG_CFG4 = 3'h4;
   localparam logic [2:0] REG_CFG5 = 3'h5;
   localparam logic [2:0] REG_CFG6 = 3'h6;
   localparam logic [2:0] LAST_REG = 3'h6;
   localparam logic [2:0] CHECK_ADDR = 3'h5;

   // ==========================================================
   // Field positions
   localparam int START_INV_BIT = 8;
   localparam int STOPA_INV_BIT = 9;
   localparam int STOPB_INV_BIT = 10;
   localparam int RANGE2_BIT = 11;
   localparam int NOCAL_BIT = 12;
   localparam int CALC_BIT = 13;
   localparam int TCLK_BIT = 14;
   localparam int DUMMY_BIT = 15;
   localparam int TCYC_BIT = 16;
   localparam int TPORT_BIT = 17;
   localparam int HSDIV_LSB = 20;
   localparam int FIREDIV_LSB = 24;
   localparam int HITA_LSB = 24;
   localparam int HITB_LSB = 28;
   localparam int FASTINIT_BIT = 23;
   localparam int DELAY_LSB = 8;
   localparam int BOTHA_BIT = 27;
   localparam int BOTHB_BIT = 28;
   localparam int TIMO_LSB = 27;
   localparam int ERRVAL_BIT = 29;
   localparam int PHASE_LSB = 8;
   localparam int REPEAT_LSB = 24;
   localparam int RESX2_BIT = 12;
   localparam int RESX4_BIT = 13;
   localparam int ANALOG_BIT = 31;
   localparam int CHECK_LSB = 24;

   // ==========================================================
   // Values after reset
   localparam logic [31:0] CFG0_RESET = 32'h02026F00;
   localparam logic [31:0] CFG1_RESET = 32'h55000000;
   localparam logic [31:0] CFG3_RESET = 32'h18000000;
   localparam logic [31:0] CFG_ZERO_RESET = 32'h00000000;
   localparam logic [2:0] PINS_IDLE = 3'h2;

   // ==========================================================
   // Serial commands and frame lengths
   localparam logic [4:0] OP_WRITE_PFX = 5'h10;
   localparam logic [4:0] OP_RESULT_PFX = 5'h16;
   localparam logic [4:0] OP_ID_PFX = 5'h18;
   localparam logic [7:0] OP_POWER_RESET = 8'h50;
   localparam logic [5:0] OP_BITS = 6'h08;
   localparam logic [5:0] OP_LAST = 6'h07;
   localparam logic [5:0] FRAME_BITS = 6'h28;
   localparam logic [5:0] FRAME_LAST = 6'h27;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic sclk;
      logic ssn_n;
      logic mosi;
   } spi_pins_t;

   typedef struct packed {
      logic opcode_valid;
      logic [7:0] opcode;
      logic word_valid;
      logic [31:0] word;
   } spi_frame_t;

   typedef struct packed {
      logic start_edge_invert;
      logic stop_a_edge_invert;
      logic stop_b_edge_invert;
      logic range_two_select;
      logic auto_cal_disable;
      logic cal_calc_enable;
      logic temp_cycle_clock_select;
      logic temp_dummy_cycles;
      logic temp_cycle_time;
      logic temp_port_count;
      logic [1:0] hs_clock_prediv;
      logic [3:0] fire_clock_prediv;
      logic [3:0] hit_select_a;
      logic [3:0] hit_select_b;
      logic fast_init_enable;
      logic [15:0] delay_value_a;
      logic [15:0] delay_value_b;
      logic [15:0] delay_value_c;
      logic stop_a_both_edges;
      logic stop_b_both_edges;
      logic [1:0] range_two_timeout_select;
      logic timeout_error_enable;
      logic [15:0] pulse_phase_pattern;
      logic [2:0] fire_repeat_count;
      logic resolution_x2_enable;
      logic resolution_x4_enable;
      logic analog_enable;
   } cfg_fields_t;

endpackage

// ==== pin_sync.sv ====
// Two-stage synchroniser for the serial pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync
   import tdc_cfg_pkg::*;
#(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // ==========================================================
   // First stage feeds only the second
   always_ff @(posedge mclk) begin
      if (srst) begin
         meta_r <= INIT;
         q <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== spi_frame_rx.sv ====
// Serial frame engine: opcode and word capture, read byte shift-out
`timescale 1ns/10ps
`default_nettype none
module spi_frame_rx
   import tdc_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire spi_pins_t pins,
   input wire logic [7:0] tx_byte,
   output spi_frame_t frame,
   output logic miso,
   output logic miso_oe
);
   logic sclk_q_r;
   logic [5:0] cnt_r;
   logic [31:0] in_r;
   logic [7:0] op_r;
   logic op_v_r;
   logic [31:0] word_r;
   logic word_v_r;
   logic [7:0] tx_r;
   logic miso_r;
   logic oe_r;

   // ==========================================================
   // Edge detection on the already synchronised clock
   wire active = ~pins.ssn_n;
   wire rise = pins.sclk & ~sclk_q_r;
   wire fall = ~pins.sclk & sclk_q_r;
   wire [31:0] in_nxt = {in_r[30:0], pins.mosi};
   wire shift_out = rise && (cnt_r >= OP_BITS);

   // Host shifts on rising edge, so sample on falling
   always_ff @(posedge mclk) begin
      if (srst) begin
         sclk_q_r <= 1'b0;
         cnt_r <= 6'h00;
         in_r <= 32'h00000000;
         op_r <= 8'h00;
         op_v_r <= 1'b0;
         word_r <= 32'h00000000;
         word_v_r <= 1'b0;
         tx_r <= 8'h00;
         miso_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         sclk_q_r <= pins.sclk;
         oe_r <= active;
         op_v_r <= active && fall && (cnt_r == OP_LAST);
         word_v_r <= active && fall && (cnt_r == FRAME_LAST);
         if (!active) begin
            cnt_r <= 6'h00; // Aborted frame restarts the count; a partial word is never committed
            miso_r <= 1'b0;
         end else begin
            if (fall) begin
               in_r <= in_nxt;
               if (cnt_r != FRAME_BITS) begin
                  cnt_r <= cnt_r + 6'h01;
               end
               if (cnt_r == OP_LAST) begin
                  op_r <= in_nxt[7:0];
               end
               if (cnt_r == FRAME_LAST) begin
                  word_r <= in_nxt;
               end
            end
            if (op_v_r) begin
               tx_r <= tx_byte;
            end else if (shift_out) begin
               miso_r <= tx_r[7];
               tx_r <= {tx_r[6:0], 1'b0};
            end
         end
      end
   end

   assign frame = '{opcode_valid: op_v_r, opcode: op_r, word_valid: word_v_r, word: word_r};
   assign miso = miso_r;
   assign miso_oe = oe_r;

   // ==========================================================
   // Checks
   a_msb_out: assert property (@(posedge mclk) disable iff (srst)
      active && shift_out && !op_v_r |=> miso_r == $past(tx_r[7]))
      else $error("read byte not sent msb first");
   a_oe_quiet: assert property (@(posedge mclk) disable iff (srst)
      !active |=> !miso_oe && !miso)
      else $error("miso driven outside frame");
   a_frame_len: assert property (@(posedge mclk) disable iff (srst)
      $rose(word_v_r) |-> cnt_r == FRAME_BITS)
      else $error("word strobe before full frame");
endmodule
`default_nettype wire

// ==== host_spi_model.sv ====
// Host controller model driving the serial pins of the configuration bank
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
   input wire logic mclk,
   input wire logic miso,
   input wire logic miso_oe,
   output var logic sclk,
   output var logic ssn_n,
   output var logic mosi
);
   logic float_r;
   logic miso_line;

   // ==========================================
   // Undriven read line toggles so stale bits never pass
   assign miso_line = miso_oe ? miso : float_r;
   always_ff @(posedge mclk) begin
      float_r <= ~float_r;
   end

   initial begin
      float_r = 1'b0;
      sclk = 1'b0;
      ssn_n = 1'b1;
      mosi = 1'b0;
   end

   // ==========================================
   // One frame, mode 1: change on rise, device samples on fall
   // Phases of 6 cycles keep clear of the 4-cycle minimum
   task automatic xfer(input logic [7:0] op, input logic [31:0] data, input int nbits,
                       output logic [7:0] rd);
      logic [39:0] fr;
      fr = {op, data};
      rd = 8'h00;
      @(negedge mclk);
      ssn_n = 1'b0;
      repeat (6) @(negedge mclk);
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b1;
         @(negedge mclk);
         mosi = fr[39-i];
         repeat (5) @(negedge mclk);
         sclk = 1'b0;
         if (i >= 8 && i < 16) begin
            rd = {rd[6:0], miso_line};
         end
         repeat (6) @(negedge mclk);
      end
      ssn_n = 1'b1;
      mosi = ~mosi;
      repeat (8) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the configuration bank against a word model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import tdc_cfg_pkg::*;
   logic mclk;
   logic srst;
   logic spi_sclk;
   logic spi_ssn_n;
   logic spi_mosi;
   logic spi_miso;
   logic spi_miso_oe;
   cfg_fields_t cfg;
   int error_cnt;
   int num_checks;
   logic [31:0] mw [0:6];
   logic [15:0] lfsr_r;
   logic [31:0] rv;
   logic [7:0] rb;

   tdc_cfg_bank i_tdc_cfg_bank (.mclk(mclk), .srst(srst), .spi_sclk(spi_sclk),
      .spi_ssn_n(spi_ssn_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .cfg(cfg));
   host_spi_model i_host_spi_model (.mclk(mclk), .miso(spi_miso), .miso_oe(spi_miso_oe),
      .sclk(spi_sclk), .ssn_n(spi_ssn_n), .mosi(spi_mosi));

   // ==========================================
   // Clock and watchdog
   always #25 mclk = ~mclk;
   initial begin
      repeat (100000) @(posedge mclk);
      error_cnt++;
      $display("BAD %0t run did not finish", $time);
      summarize();
   end

   // ==========================================
   // Model of the seven words
   task automatic model_reset();
      for (int n = 0; n < 7; n++) begin
         mw[n] = CFG_ZERO_RESET;
      end
      mw[0] = CFG0_RESET;
      mw[1] = CFG1_RESET;
      mw[3] = CFG3_RESET;
   endtask

   function automatic cfg_fields_t exp_cfg();
      return {mw[0][8], mw[0][9], mw[0][10], mw[0][11], mw[0][12], mw[0][13],
         mw[0][14], mw[0][15], mw[0][16], mw[0][17], mw[0][21:20], mw[0][27:24],
         mw[1][27:24], mw[1][31:28], mw[1][23], mw[2][23:8], mw[3][23:8], mw[4][23:8],
         mw[2][27], mw[2][28], mw[3][28:27], mw[3][29], mw[5][23:8], mw[5][26:24],
         mw[6][12], mw[6][13], mw[6][31]};
   endfunction

   // Sixteen-bit shift register, thirty-two steps per word, one per bit
   task automatic rnd(output logic [31:0] v);
      for (int k = 0; k < 32; k++) begin
         lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
         v[k] = lfsr_r[0];
      end
   endtask

   task automatic chk(input logic [$bits(cfg_fields_t)-1:0] got,
                      input logic [$bits(cfg_fields_t)-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // ==========================================
   // Host transfers
   task automatic wr(input int n, input logic [31:0] d);
      logic [7:0] r;
      i_host_spi_model.xfer(8'h80 | 8'(n), d, 40, r);
      if (n < 7) begin
         mw[n] = d;
      end
   endtask

   task automatic rd_chk(input logic [7:0] op, input logic [7:0] exp);
      logic [7:0] r;
      i_host_spi_model.xfer(op, 32'h00000000, 16, r);
      chk(r, exp);
   endtask

   task automatic tags_chk();
      for (int n = 0; n < 7; n++) begin
         rd_chk(8'hC0 | 8'(n), mw[n][7:0]);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      mclk = 1'b0;
      srst = 1'b1;
      error_cnt = 0;
      num_checks = 0;
      lfsr_r = 16'h0050;
      model_reset();
      repeat (2) @(negedge mclk);
      srst = 1'b0;
      repeat (4) @(negedge mclk);
      chk(cfg, exp_cfg());
      tags_chk();
      rd_chk(8'hB5, 8'h55);
      // Random words twice over, every register
      for (int p = 0; p < 2; p++) begin
         for (int n = 0; n < 7; n++) begin
            rnd(rv);
            wr(n, rv);
            chk(cfg, exp_cfg());
         end
         tags_chk();
         rd_chk(8'hB5, mw[1][31:24]);
         rd_chk(8'hB2, 8'h00);
      end
      // Word seven does not exist
      rnd(rv);
      wr(7, rv);
      chk(cfg, exp_cfg());
      // Frame cut short leaves everything alone
      rnd(rv);
      i_host_spi_model.xfer(8'h81, rv, 24, rb);
      chk(cfg, exp_cfg());
      tags_chk();
      // Reset command restores defaults
      i_host_spi_model.xfer(8'h50, 32'h00000000, 8, rb);
      model_reset();
      chk(cfg, exp_cfg());
      tags_chk();
      // Pin reset in mid-run
      rnd(rv);
      wr(6, rv);
      chk(cfg, exp_cfg());
      srst = 1'b1;
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      model_reset();
      repeat (4) @(negedge mclk);
      chk(cfg, exp_cfg());
      rd_chk(8'hC6, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
